//--- logic/tie_params.svh
// offsets, field positions, reset values and timing counts for the top-level interrupt block
// assumes inclusion from the block's module only
`ifndef TIE_PARAMS_SVH
`define TIE_PARAMS_SVH
`define TIE_ADDR_ENABLE_SET    32'hE000_E100
`define TIE_ADDR_ENABLE_CLEAR  32'hE000_E180
`define TIE_ADDR_EVENT_STATUS  32'hE000_E400
`define TIE_ADDR_EVENT_MASK    32'hE000_E404
`define TIE_ADDR_FAULT_STATUS  32'hE000_E408
`define TIE_ADDR_CLOCK_STATUS  32'hE000_E40C
`define TIE_ENABLE_RESET       17'h0_0000
`define TIE_NUM_IRQ            17
`define TIE_FLT_SIZE           0
`define TIE_FLT_PROT           1
`define TIE_FLT_UNMAP          2
`define TIE_FLT_REPEAT         3
`define TIE_EVT_XTAL           0
`define TIE_EVT_WDOG           1
`define TIE_EVT_BUSFLT         2
`define TIE_XTAL_FAIL_NS       1000
`define TIE_CLK_NS             8
`define TIE_XTAL_FAIL_CYC      ((`TIE_XTAL_FAIL_NS + `TIE_CLK_NS - 1) / `TIE_CLK_NS)
`define TIE_WDOG_MS            1792
`define TIE_WDOG_CYC           ((`TIE_WDOG_MS * 1000000) / `TIE_CLK_NS)
`define TIE_SWITCH_CYC         4
`endif

//--- logic/tie_pkg.sv
// types shared by the top-level interrupt block
// assumes tie_params.svh beside it
package tie_pkg;
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [1:0]  size;
        logic        write;
        logic        user;
        logic        apb;
        logic        sys_periph;
        logic        prot_ram;
        logic        beyond_reg;
        logic        beyond_mem;
    } tie_access_s;
    typedef enum logic [1:0] {
        TIE_SIZE_BYTE,
        TIE_SIZE_HALF,
        TIE_SIZE_WORD,
        TIE_SIZE_RSVD
    } tie_size_e;
    typedef enum {
        TIE_CK_XTAL,
        TIE_CK_SWITCH,
        TIE_CK_RC
    } tie_clk_e;
endpackage

//--- logic/tie_top.sv
// top-level interrupt enables, non-maskable sources and bus-fault recording
// assumes one clock mclk, peripherals driving level requests, bus checks from the fabric
`timescale 1ns/1ps
`include "tie_params.svh"

// Function
// - non-maskable interrupt comes only from crystal failure and watchdog low water
// - crystal stopping while selected forces core clock over to internal RC
// - after detection and switch, set crystal failure flag, raising non-maskable interrupt
// - active watchdog left unreset for low-water interval sets its flag
// - each bus-fault cause its own status bit; one access may set several
// - byte or halfword peripheral-bus access, or unaligned word, flags size fault
// - unprivileged write to system peripheral or protected RAM flags protection fault
// - access beyond last register or above memory top flags unmapped fault
// - second bus fault sets repeated bit and raises hard fault
// - writing one to enable-set bit enables; zeros leave enables alone
// - writing one to enable-clear bit disables; zeros leave enables alone
// - bit 16 debug, 15-12 pins D-A, 11 converter, 10-8 radio rx, tx, timer
// - bits 7-0 security, serial two, serial one, sleep, baseband, management, timers
// - top-level requests are levels following second-level flags
module tie_top
    import tie_pkg::*;
#(
    parameter int unsigned WDOG_CYC = `TIE_WDOG_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        debug_irq,
    input  wire logic        pin_irq_d,
    input  wire logic        pin_irq_c,
    input  wire logic        pin_irq_b,
    input  wire logic        pin_irq_a,
    input  wire logic        adc_irq,
    input  wire logic        radio_rx_irq,
    input  wire logic        radio_tx_irq,
    input  wire logic        radio_timer_irq,
    input  wire logic        security_irq,
    input  wire logic        serial_two_irq,
    input  wire logic        serial_one_irq,
    input  wire logic        sleep_timer_irq,
    input  wire logic        baseband_irq,
    input  wire logic        management_irq,
    input  wire logic        timer_two_irq,
    input  wire logic        timer_one_irq,
    output logic      [16:0] core_irq,
    input  wire logic        xtal_clk,
    input  wire logic        xtal_selected,
    input  wire logic        wdog_active,
    input  wire logic        wdog_kick,
    output logic             core_clock_sel_rc,
    output logic             nmi,
    input  wire tie_access_s bus_access,
    output logic             bus_fault,
    output logic             hard_fault,
    output logic             irq
);
    logic [16:0] req;
    logic [16:0] enable;
    logic [16:0] next_enable;
    logic [2:0]  evt_status;
    logic [2:0]  next_evt_status;
    logic [2:0]  evt_mask;
    logic [2:0]  next_evt_mask;
    logic [3:0]  fault_status;
    logic [3:0]  next_fault_status;
    logic [2:0]  xtal_sync;
    logic        xtal_prev;
    logic [7:0]  xtal_quiet;
    logic [7:0]  next_xtal_quiet;
    logic [2:0]  sw_cnt;
    logic [2:0]  next_sw_cnt;
    tie_clk_e    ck_state;
    tie_clk_e    next_ck_state;
    logic [31:0] wdog_cnt;
    logic [31:0] next_wdog_cnt;
    logic [31:0] next_rdata;
    logic [3:0]  flt_hit;
    logic [2:0]  evt_hit;
    logic        wdog_hit;
    logic        xtal_done;

    // level requests in enable-bit order
    assign req = {debug_irq, pin_irq_d, pin_irq_c, pin_irq_b, pin_irq_a, adc_irq,
                  radio_rx_irq, radio_tx_irq, radio_timer_irq,
                  security_irq, serial_two_irq, serial_one_irq, sleep_timer_irq,
                  baseband_irq, management_irq, timer_two_irq, timer_one_irq};

    genvar gi;
    generate
        for (gi = 0; gi < `TIE_NUM_IRQ; gi++) begin : g_gate
            assign core_irq[gi] = req[gi] & enable[gi];
        end
    endgenerate

    // crystal edge activity, sampled through three flops
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xtal_sync <= 3'h0;
            xtal_prev <= 1'b0;
        end else begin
            xtal_sync <= {xtal_sync[1:0], xtal_clk};
            if (xtal_sync[1] == xtal_sync[2]) begin
                xtal_prev <= xtal_sync[2];
            end
        end
    end

    always_comb begin
        next_xtal_quiet = xtal_quiet;
        next_sw_cnt     = sw_cnt;
        next_ck_state   = ck_state;
        xtal_done       = 1'b0;
        if (xtal_sync[1] == xtal_sync[2] && xtal_sync[2] != xtal_prev) begin
            next_xtal_quiet = 8'h00;
        end else if (xtal_quiet != 8'(`TIE_XTAL_FAIL_CYC)) begin
            next_xtal_quiet = xtal_quiet + 8'h01;
        end
        unique case (ck_state)
            TIE_CK_XTAL: begin
                if (xtal_selected && xtal_quiet == 8'(`TIE_XTAL_FAIL_CYC)) begin
                    next_ck_state = TIE_CK_SWITCH;
                    next_sw_cnt   = 3'h0;
                end
            end
            TIE_CK_SWITCH: begin
                next_sw_cnt = sw_cnt + 3'h1;
                if (sw_cnt == 3'(`TIE_SWITCH_CYC - 1)) begin
                    next_ck_state = TIE_CK_RC;
                    xtal_done     = 1'b1;
                end
            end
            TIE_CK_RC: begin
                next_ck_state = TIE_CK_RC;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            xtal_quiet <= 8'h00;
            sw_cnt     <= 3'h0;
            ck_state   <= TIE_CK_XTAL;
        end else begin
            xtal_quiet <= next_xtal_quiet;
            sw_cnt     <= next_sw_cnt;
            ck_state   <= next_ck_state;
        end
    end

    assign core_clock_sel_rc = (ck_state != TIE_CK_XTAL);

    // watchdog low-water counter
    always_comb begin
        next_wdog_cnt = wdog_cnt;
        wdog_hit      = 1'b0;
        if (!wdog_active || wdog_kick) begin
            next_wdog_cnt = 32'h0000_0000;
        end else if (wdog_cnt == WDOG_CYC - 1) begin
            wdog_hit      = 1'b1;
            next_wdog_cnt = 32'h0000_0000;
        end else begin
            next_wdog_cnt = wdog_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wdog_cnt <= 32'h0000_0000;
        end else begin
            wdog_cnt <= next_wdog_cnt;
        end
    end

    // bus-fault causes
    always_comb begin
        flt_hit = 4'h0;
        if (bus_access.valid) begin
            flt_hit[`TIE_FLT_SIZE] = (bus_access.apb && bus_access.size != TIE_SIZE_WORD) ||
                                     (bus_access.size == TIE_SIZE_WORD && bus_access.addr[1:0] != 2'h0);
            flt_hit[`TIE_FLT_PROT] = bus_access.user && bus_access.write &&
                                     (bus_access.sys_periph || bus_access.prot_ram);
            flt_hit[`TIE_FLT_UNMAP] = bus_access.beyond_reg || bus_access.beyond_mem;
        end
    end

    assign bus_fault  = |flt_hit[2:0];
    assign hard_fault = bus_fault && (|fault_status[2:0]);
    assign evt_hit    = {bus_fault, wdog_hit, xtal_done};

    // register file and sticky flags, set beats clear
    always_comb begin
        next_enable       = enable;
        next_evt_status   = evt_status | evt_hit;
        next_evt_mask     = evt_mask;
        next_fault_status = fault_status;
        next_rdata        = 32'h0000_0000;
        if (wr) begin
            unique case (addr)
                `TIE_ADDR_ENABLE_SET:   next_enable = enable | wdata[16:0];
                `TIE_ADDR_ENABLE_CLEAR: next_enable = enable & ~wdata[16:0];
                `TIE_ADDR_EVENT_STATUS: next_evt_status = (evt_status & ~wdata[2:0]) | evt_hit;
                `TIE_ADDR_EVENT_MASK:   next_evt_mask = wdata[2:0];
                `TIE_ADDR_FAULT_STATUS: next_fault_status = fault_status & ~wdata[3:0];
                default: ;
            endcase
        end
        next_fault_status = next_fault_status | flt_hit;
        if (bus_fault && (|fault_status[2:0])) begin
            next_fault_status[`TIE_FLT_REPEAT] = 1'b1;
        end
        if (rd) begin
            unique case (addr)
                `TIE_ADDR_ENABLE_SET,
                `TIE_ADDR_ENABLE_CLEAR: next_rdata = {15'h0000, enable};
                `TIE_ADDR_EVENT_STATUS: next_rdata = {29'h0000_0000, evt_status};
                `TIE_ADDR_EVENT_MASK:   next_rdata = {29'h0000_0000, evt_mask};
                `TIE_ADDR_FAULT_STATUS: next_rdata = {28'h000_0000, fault_status};
                `TIE_ADDR_CLOCK_STATUS: next_rdata = {31'h0000_0000, core_clock_sel_rc};
                default:                next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enable       <= `TIE_ENABLE_RESET;
            evt_status   <= 3'h0;
            evt_mask     <= 3'h0;
            fault_status <= 4'h0;
            rdata        <= 32'h0000_0000;
        end else begin
            enable       <= next_enable;
            evt_status   <= next_evt_status;
            evt_mask     <= next_evt_mask;
            fault_status <= next_fault_status;
            rdata        <= next_rdata;
        end
    end

    // non-maskable level from the two second-level flags only
    assign nmi = evt_status[`TIE_EVT_XTAL] | evt_status[`TIE_EVT_WDOG];
    assign irq = |(evt_status & evt_mask);

    AST_NMI_SRC: assert property (@(posedge mclk) disable iff (rst)
        $rose(nmi) |-> $past(xtal_done || wdog_hit)) else $error("nmi from other source");
    AST_SWITCH: assert property (@(posedge mclk) disable iff (rst)
        (ck_state == TIE_CK_XTAL && next_ck_state == TIE_CK_SWITCH) |=> core_clock_sel_rc)
        else $error("clock not switched");
    sequence s_switching;
        ck_state == TIE_CK_SWITCH [*4];
    endsequence
    AST_XTAL_FLAG: assert property (@(posedge mclk) disable iff (rst)
        s_switching ##1 (ck_state == TIE_CK_RC) |-> evt_status[0] && nmi)
        else $error("crystal flag not set after switch");
    AST_WDOG: assert property (@(posedge mclk) disable iff (rst)
        wdog_hit |=> evt_status[1] && nmi) else $error("watchdog flag missing");
    AST_FLT: assert property (@(posedge mclk) disable iff (rst)
        bus_access.valid |=> ((fault_status[2:0] & $past(flt_hit[2:0])) == $past(flt_hit[2:0])))
        else $error("fault cause lost");
    AST_SIZE: assert property (@(posedge mclk) disable iff (rst)
        (bus_access.valid && bus_access.apb && bus_access.size == TIE_SIZE_BYTE) |=> fault_status[0])
        else $error("size fault missing");
    AST_PROT: assert property (@(posedge mclk) disable iff (rst)
        (bus_access.valid && bus_access.user && bus_access.write && bus_access.prot_ram)
        |=> fault_status[1]) else $error("protection fault missing");
    AST_UNMAP: assert property (@(posedge mclk) disable iff (rst)
        (bus_access.valid && bus_access.beyond_mem) |=> fault_status[2]) else $error("unmapped fault missing");
    AST_REPEAT: assert property (@(posedge mclk) disable iff (rst)
        (bus_fault && |fault_status[2:0]) |-> hard_fault ##1 fault_status[3])
        else $error("repeat fault missing");
    AST_SET: assert property (@(posedge mclk) disable iff (rst)
        (wr && addr == `TIE_ADDR_ENABLE_SET) |=> enable == ($past(enable) | $past(wdata[16:0])))
        else $error("enable set wrong");
    AST_CLR: assert property (@(posedge mclk) disable iff (rst)
        (wr && addr == `TIE_ADDR_ENABLE_CLEAR) |=> enable == ($past(enable) & ~$past(wdata[16:0])))
        else $error("enable clear wrong");
    AST_READ: assert property (@(posedge mclk) disable iff (rst)
        (rd && addr == `TIE_ADDR_ENABLE_CLEAR) |=> rdata == {15'h0000, $past(enable)})
        else $error("enable readback wrong");
    AST_GATE: assert property (@(posedge mclk) disable iff (rst)
        core_irq[16] == (debug_irq && enable[16]) && core_irq[0] == (timer_one_irq && enable[0]))
        else $error("ungated request");
endmodule

//--- bench/tie_far_model.sv
// far-side model: main crystal oscillator and watchdog service routine
// assumes the bench gates crystal and servicing through the run inputs
`timescale 1ns/1ps
module tie_far_model (
    input  wire logic mclk,
    input  wire logic xtal_run,
    input  wire logic kick_run,
    output logic      xtal_clk,
    output logic      wdog_kick
);
    logic [4:0] kick_cnt = 5'h0;
    // stopped crystal freezes at its last level
    initial begin
        xtal_clk = 1'b0;
        forever begin
            #20.833;
            if (xtal_run) begin
                xtal_clk = ~xtal_clk;
            end
        end
    end
    // service well inside the low-water interval
    always @(posedge mclk) begin
        kick_cnt  <= kick_cnt + 5'h1;
        wdog_kick <= kick_run && (kick_cnt == 5'h0);
    end
endmodule

//--- bench/top_irq_enable_nmi_busfault_bench.sv
// self-checking bench for the top-level interrupt block
// assumes tie_top with a short watchdog count and the far-side model
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module top_irq_enable_nmi_busfault_bench;
    import tie_pkg::*;
    localparam logic [31:0] A_SET = 32'hE000_E100;
    localparam logic [31:0] A_CLR = 32'hE000_E180;
    localparam logic [31:0] A_EVT = 32'hE000_E400;
    localparam logic [31:0] A_MSK = 32'hE000_E404;
    localparam logic [31:0] A_FLT = 32'hE000_E408;
    localparam logic [31:0] A_CKS = 32'hE000_E40C;
    localparam logic [1:0]  SZ [8] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h0};
    localparam logic [6:0]  FL [8] = '{7'h10, 7'h50, 7'h00, 7'h68, 7'h64, 7'h12, 7'h01, 7'h7A};
    localparam logic [31:0] EX [8] = '{32'h1, 32'h1, 32'h1, 32'h2, 32'h2, 32'h4, 32'h4, 32'h7};
    logic        mclk, rst, wr, rd, xtal_selected, wdog_active, xtal_run, kick_run;
    logic [31:0] addr, wdata, rdata;
    logic [16:0] req, core_irq;
    logic        xtal_clk, wdog_kick, sel_rc, nmi, bus_fault, hard_fault, irq;
    tie_access_s acc;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          n;
    tie_top #(.WDOG_CYC(50)) tie_top_i (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .debug_irq(req[16]), .pin_irq_d(req[15]), .pin_irq_c(req[14]), .pin_irq_b(req[13]),
        .pin_irq_a(req[12]), .adc_irq(req[11]), .radio_rx_irq(req[10]), .radio_tx_irq(req[9]),
        .radio_timer_irq(req[8]), .security_irq(req[7]), .serial_two_irq(req[6]),
        .serial_one_irq(req[5]), .sleep_timer_irq(req[4]), .baseband_irq(req[3]),
        .management_irq(req[2]), .timer_two_irq(req[1]), .timer_one_irq(req[0]),
        .core_irq(core_irq), .xtal_clk(xtal_clk), .xtal_selected(xtal_selected),
        .wdog_active(wdog_active), .wdog_kick(wdog_kick), .core_clock_sel_rc(sel_rc), .nmi(nmi),
        .bus_access(acc), .bus_fault(bus_fault), .hard_fault(hard_fault), .irq(irq));
    tie_far_model tie_far_model_i (
        .mclk(mclk), .xtal_run(xtal_run), .kick_run(kick_run), .xtal_clk(xtal_clk),
        .wdog_kick(wdog_kick));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    // one-cycle access descriptor; fault flags are combinational in that cycle
    task automatic fault_acc(input logic [1:0] sz, input logic [6:0] fl, input logic hf);
        @(posedge mclk);
        acc <= tie_access_s'({1'b1, (sz == 2'h2 && fl == 7'h00) ? 32'h2000_0002 : 32'h4000_0000, sz, fl});
        #1;
        `CHK(bus_fault, 1'b1)
        `CHK(hard_fault, hf)
        @(posedge mclk);
        acc <= '0;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #160000;
        miscompares++;
        test_done();
    end
    initial begin
        rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = '0; wdata = '0; req = '0; acc = '0;
        xtal_selected = 1'b1; wdog_active = 1'b0; xtal_run = 1'b1; kick_run = 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd_chk(A_SET, 32'h0000_0000);
        rd_chk(A_CLR, 32'h0000_0000);
        reg_wr(A_SET, 32'hFFFF_FFFF);
        rd_chk(A_SET, 32'h0001_FFFF);
        reg_wr(A_CLR, 32'h0000_00F0);
        reg_wr(A_SET, 32'h0000_0000);
        rd_chk(A_CLR, 32'h0001_FF0F);
        reg_wr(32'hE000_E500, 32'hFFFF_FFFF);
        rd_chk(32'hE000_E500, 32'h0000_0000);
        $display("enable register test done");
        reg_wr(A_SET, 32'h0001_FFFF);
        for (int i = 0; i < 17; i++) begin
            req <= 17'h1 << i;
            @(posedge mclk);
            #1;
            `CHK(core_irq, 17'h1 << i)
        end
        req <= 17'h1_FFFF;
        reg_wr(A_CLR, 32'h0001_5555);
        `CHK(core_irq, 17'h0_AAAA)
        req <= 17'h0_0000;
        @(posedge mclk);
        #1;
        `CHK(core_irq, 17'h0_0000)
        $display("request routing test done");
        wdog_active <= 1'b1;
        repeat (150) @(posedge mclk);
        #1;
        `CHK(nmi, 1'b0)
        kick_run <= 1'b0;
        for (n = 0; n < 100 && nmi !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        `CHK(nmi, 1'b1)
        wdog_active <= 1'b0;
        rd_chk(A_EVT, 32'h0000_0002);
        reg_wr(A_EVT, 32'h0000_0002);
        `CHK(nmi, 1'b0)
        $display("watchdog test done");
        xtal_run <= 1'b0;
        for (n = 0; n < 300 && sel_rc !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        `CHK(sel_rc, 1'b1)
        `CHK(nmi, 1'b0)
        for (n = 0; n < 10 && nmi !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        `CHK(nmi, 1'b1)
        xtal_selected <= 1'b0;
        rd_chk(A_EVT, 32'h0000_0001);
        reg_wr(A_CKS, 32'h0000_0000);
        rd_chk(A_CKS, 32'h0000_0001);
        reg_wr(A_EVT, 32'h0000_0001);
        `CHK(nmi, 1'b0)
        `CHK(sel_rc, 1'b1)
        $display("crystal failure test done");
        for (int i = 0; i < 8; i++) begin
            fault_acc(SZ[i], FL[i], 1'b0);
            rd_chk(A_FLT, EX[i]);
            reg_wr(A_FLT, 32'h0000_000F);
        end
        fault_acc(2'h0, 7'h10, 1'b0);
        fault_acc(2'h2, 7'h01, 1'b1);
        rd_chk(A_FLT, 32'h0000_000D);
        `CHK(nmi, 1'b0)
        rd_chk(A_EVT, 32'h0000_0004);
        reg_wr(A_MSK, 32'h0000_0003);
        `CHK(irq, 1'b0)
        reg_wr(A_MSK, 32'h0000_0004);
        `CHK(irq, 1'b1)
        reg_wr(A_EVT, 32'h0000_0004);
        `CHK(irq, 1'b0)
        $display("bus fault and interrupt test done");
        test_done();
    end
endmodule
